// >>> verilog/ebt_pkg.sv
package ebt_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_COUNT_VALUE = 8'hea;
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'heb;
  localparam logic [7:0] IDX_CH0_CONTROL = 8'hec;
  localparam logic [7:0] IDX_CH0_VALUE = 8'hed;
  localparam logic [7:0] IDX_CH1_CONTROL = 8'hee;
  localparam logic [7:0] IDX_CH1_VALUE = 8'hef;
  localparam logic [7:0] IDX_PENDING_FLAGS = 8'hf0;

  // ---------------------------------------------------------------
  // timer_control fields
  // ---------------------------------------------------------------
  localparam int DIV_MSB = 7;
  localparam int DIV_LSB = 5;
  localparam int RUN_BIT = 4;
  localparam int OVF_MASK_BIT = 3;
  localparam int CLEAR_BIT = 2;
  localparam int MODE_MSB = 1;
  localparam int MODE_LSB = 0;
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h08;

  localparam logic [1:0] MODE_FREE = 2'h0;
  localparam logic [1:0] MODE_DOWN = 2'h1;
  localparam logic [1:0] MODE_MODULO = 2'h2;
  localparam logic [1:0] MODE_UPDOWN = 2'h3;

  // ---------------------------------------------------------------
  // channel control fields
  // ---------------------------------------------------------------
  localparam int CH_MASK_BIT = 6;
  localparam int ACT_MSB = 5;
  localparam int ACT_LSB = 3;
  localparam int CH_EN_BIT = 2;
  localparam int RSV_MSB = 1;
  localparam logic [7:0] CH_CONTROL_RESET = 8'h40;
  localparam logic [7:0] COMPARE_VALUE_RESET = 8'h00;

  localparam logic [2:0] ACT_SET = 3'h0;
  localparam logic [2:0] ACT_CLEAR = 3'h1;
  localparam logic [2:0] ACT_TOGGLE = 3'h2;
  localparam logic [2:0] ACT_SET_UP_CLR_ZERO = 3'h3;
  localparam logic [2:0] ACT_CLR_UP_SET_ZERO = 3'h4;
  localparam logic [2:0] ACT_SET_CLR_ALT = 3'h5;
  localparam logic [2:0] ACT_CLR_SET_ALT = 3'h6;

  // ---------------------------------------------------------------
  // pending flag positions, counter limits, bus answers
  // ---------------------------------------------------------------
  localparam int OVF_PEND_BIT = 3;
  localparam int CH0_PEND_BIT = 4;
  localparam int CH1_PEND_BIT = 5;
  localparam logic [7:0] COUNT_TOP = 8'hff;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam int PRESCALE_W = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> verilog/ebt_chan_if.sv
`timescale 1ns/100ps
interface ebt_chan_if;
  logic [7:0] count;
  logic step;
  logic updown;
  logic down_leg;
  logic enable;
  logic [2:0] action;
  logic [7:0] compare_value;
  logic [7:0] alt_clear_value;
  logic [7:0] alt_set_value;
  logic event_hit;
  logic level;

  modport timer (
    output count, step, updown, down_leg, enable, action,
    output compare_value, alt_clear_value, alt_set_value,
    input event_hit, level
  );
  modport channel (
    input count, step, updown, down_leg, enable, action,
    input compare_value, alt_clear_value, alt_set_value,
    output event_hit, level
  );
endinterface

// >>> verilog/ebt_prescaler.sv
`timescale 1ns/100ps
module ebt_prescaler #(
  parameter int DIV_W = ebt_pkg::PRESCALE_W
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic tick_in,
  input wire logic run_in,
  input wire logic [2:0] div_code_in,
  output logic edge_out
);

  logic [DIV_W-1:0] phase_r;
  logic [DIV_W:0] one_hot;
  logic [DIV_W-1:0] mask;

  // the mask follows the code directly, so a new ratio acts on the next tick
  assign one_hot = (DIV_W+1)'(1) << div_code_in;
  assign mask = DIV_W'(one_hot - (DIV_W+1)'(1));
  assign edge_out = tick_in && run_in && ((phase_r & mask) == '0);

  // suspended timer freezes the phase too
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      phase_r <= '0;
    end else if (tick_in && run_in) begin
      phase_r <= phase_r + DIV_W'(1);
    end
  end

endmodule

// >>> verilog/ebt_compare_channel.sv
`timescale 1ns/100ps
module ebt_compare_channel (
  input wire logic clk_in,
  input wire logic reset_in,
  ebt_chan_if.channel ch
);

  logic match;
  logic zero_hit;
  logic alt_clr_hit;
  logic alt_set_hit;
  logic up_leg;
  logic level_r;

  assign match = ch.step && ch.enable && (ch.count == ch.compare_value);
  assign zero_hit = ch.step && ch.enable && (ch.count == ebt_pkg::COUNT_ZERO);
  assign alt_clr_hit = ch.step && ch.enable && (ch.count == ch.alt_clear_value);
  assign alt_set_hit = ch.step && ch.enable && (ch.count == ch.alt_set_value);
  // outside up/down mode every match counts as an upward one
  assign up_leg = !(ch.updown && ch.down_leg);
  assign ch.event_hit = match;
  assign ch.level = level_r;

  // a match takes priority over the secondary set/clear condition
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      level_r <= 1'b0;
    end else begin
      unique case (ch.action)
        ebt_pkg::ACT_SET: if (match) level_r <= 1'b1;
        ebt_pkg::ACT_CLEAR: if (match) level_r <= 1'b0;
        ebt_pkg::ACT_TOGGLE: if (match) level_r <= !level_r;
        ebt_pkg::ACT_SET_UP_CLR_ZERO: begin
          if (match && up_leg) begin
            level_r <= 1'b1;
          end else if (ch.updown ? (match && !up_leg) : zero_hit) begin
            level_r <= 1'b0;
          end
        end
        ebt_pkg::ACT_CLR_UP_SET_ZERO: begin
          if (match && up_leg) begin
            level_r <= 1'b0;
          end else if (ch.updown ? (match && !up_leg) : zero_hit) begin
            level_r <= 1'b1;
          end
        end
        ebt_pkg::ACT_SET_CLR_ALT: begin
          if (match) begin
            level_r <= 1'b1;
          end else if (alt_clr_hit) begin
            level_r <= 1'b0;
          end
        end
        ebt_pkg::ACT_CLR_SET_ALT: begin
          if (match) begin
            level_r <= 1'b0;
          end else if (alt_set_hit) begin
            level_r <= 1'b1;
          end
        end
        default: level_r <= level_r;
      endcase
    end
  end

endmodule

// >>> verilog/ebt_timer.sv
// Summary of operation
// - counter register is read-only, eight bits, resets zero
// - prescaler field divides tick by 1 to 128
// - prescaler change takes effect immediately
// - clear bit zeroes counter, always reads 0
// - mode 00 free-runs 0 to 255, wraps
// - mode 01 counts down from compare 0
// - mode 10 counts up to compare 0, restarts
// - mode 11 counts up then down repeatedly
// - channel acts when count equals its value
// - channel 0 compares only when enabled
// - channel 1 compares only when enabled
// - actions: set, clear, toggle on match
// - up-match set/clear, opposite at zero/down-match
// - channel 0 alternate point is 255 or 0
// - channel 1 alternate point is compare 0 value
// - channel interrupt mask bit 6, resets 1
// - channel 0 compare value register, resets zero
// - channel 1 compare value register, resets zero
// - overflow sets pending flag, write 0 clears
// - channel 0 event sets pending flag
// - channel 1 event sets pending flag
`timescale 1ns/100ps
module ebt_timer #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic tick_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [1:0] compare_out,
  output logic [2:0] irq_request_out
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] count_r;
  logic [2:0] div_r;
  logic run_r;
  logic overflow_irq_mask_r;
  logic [1:0] mode_r;
  logic [7:0] ch_ctrl_r [2];
  logic [7:0] ch_value_r [2];
  logic overflow_pending_r;
  logic channel0_pending_r;
  logic channel1_pending_r;
  logic down_leg_r;
  logic step_r;
  logic overflow_evt_r;
  logic [2:0] irq_r;

  // ---------------------------------------------------------------
  // bus slave state
  // ---------------------------------------------------------------
  logic aw_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic w_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  logic do_write;
  logic wr_lane;
  logic [7:0] wr_idx;
  logic [7:0] wr_byte;
  logic wr_ctrl;
  logic wr_flags;
  logic wr_mapped;
  logic [7:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_mapped;
  logic prescale_edge;
  logic load_down;
  logic [7:0] count_nxt;
  logic down_leg_nxt;
  logic overflow_nxt;
  logic [1:0] ch_event;
  logic [1:0] ch_level;

  // ---------------------------------------------------------------
  // write channel: address and data taken in either order
  // ---------------------------------------------------------------
  assign s_axi_awready_out = !aw_held_r && !bvalid_r;
  assign s_axi_wready_out = !w_held_r && !bvalid_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign do_write = aw_held_r && w_held_r && !bvalid_r;
  assign wr_idx = aw_addr_r[9:2];
  assign wr_lane = do_write && w_strb_r[0] && wr_mapped;
  assign wr_byte = w_data_r[7:0];
  assign wr_ctrl = wr_lane && (wr_idx == ebt_pkg::IDX_TIMER_CONTROL);
  assign wr_flags = wr_lane && (wr_idx == ebt_pkg::IDX_PENDING_FLAGS);
  assign wr_mapped = (aw_addr_r[ADDR_W-1:10] == '0) && (aw_addr_r[1:0] == 2'h0)
    && (wr_idx >= ebt_pkg::IDX_COUNT_VALUE) && (wr_idx <= ebt_pkg::IDX_PENDING_FLAGS);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_in;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata_in;
        w_strb_r <= s_axi_wstrb_in;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      bvalid_r <= 1'b0;
      bresp_r <= ebt_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_mapped ? ebt_pkg::RESP_OKAY : ebt_pkg::RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready_in) begin
      bvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      div_r <= ebt_pkg::TIMER_CONTROL_RESET[ebt_pkg::DIV_MSB:ebt_pkg::DIV_LSB];
      run_r <= ebt_pkg::TIMER_CONTROL_RESET[ebt_pkg::RUN_BIT];
      overflow_irq_mask_r <= ebt_pkg::TIMER_CONTROL_RESET[ebt_pkg::OVF_MASK_BIT];
      mode_r <= ebt_pkg::TIMER_CONTROL_RESET[ebt_pkg::MODE_MSB:ebt_pkg::MODE_LSB];
    end else if (wr_ctrl) begin
      div_r <= wr_byte[ebt_pkg::DIV_MSB:ebt_pkg::DIV_LSB];
      run_r <= wr_byte[ebt_pkg::RUN_BIT];
      overflow_irq_mask_r <= wr_byte[ebt_pkg::OVF_MASK_BIT];
      mode_r <= wr_byte[ebt_pkg::MODE_MSB:ebt_pkg::MODE_LSB];
    end
  end

  // reserved low bits are stored as written; software keeps them zero
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ch_ctrl_r[0] <= ebt_pkg::CH_CONTROL_RESET;
      ch_ctrl_r[1] <= ebt_pkg::CH_CONTROL_RESET;
      ch_value_r[0] <= ebt_pkg::COMPARE_VALUE_RESET;
      ch_value_r[1] <= ebt_pkg::COMPARE_VALUE_RESET;
    end else if (wr_lane) begin
      unique case (wr_idx)
        ebt_pkg::IDX_CH0_CONTROL: ch_ctrl_r[0] <= {1'b0, wr_byte[6:0]};
        ebt_pkg::IDX_CH1_CONTROL: ch_ctrl_r[1] <= {1'b0, wr_byte[6:0]};
        ebt_pkg::IDX_CH0_VALUE: ch_value_r[0] <= wr_byte;
        ebt_pkg::IDX_CH1_VALUE: ch_value_r[1] <= wr_byte;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // prescaler and counter
  // ---------------------------------------------------------------
  ebt_prescaler #(
    .DIV_W(ebt_pkg::PRESCALE_W)
  ) u_prescaler (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .tick_in(tick_in),
    .run_in(run_r),
    .div_code_in(div_r),
    .edge_out(prescale_edge)
  );

  // starting the timer in down mode reloads the count from channel 0
  assign load_down = wr_ctrl && wr_byte[ebt_pkg::RUN_BIT] && !run_r
    && (wr_byte[ebt_pkg::MODE_MSB:ebt_pkg::MODE_LSB] == ebt_pkg::MODE_DOWN);

  always_comb begin
    count_nxt = count_r;
    down_leg_nxt = down_leg_r;
    overflow_nxt = 1'b0;
    unique case (mode_r)
      ebt_pkg::MODE_FREE: begin
        count_nxt = count_r + 8'h01;
        overflow_nxt = (count_r == ebt_pkg::COUNT_TOP);
        down_leg_nxt = 1'b0;
      end
      ebt_pkg::MODE_DOWN: begin
        // stops at zero until restarted
        if (count_r != ebt_pkg::COUNT_ZERO) begin
          count_nxt = count_r - 8'h01;
          overflow_nxt = (count_r == 8'h01);
        end
        down_leg_nxt = 1'b1;
      end
      ebt_pkg::MODE_MODULO: begin
        if (count_r == ch_value_r[0]) begin
          count_nxt = ebt_pkg::COUNT_ZERO;
          overflow_nxt = 1'b1;
        end else begin
          count_nxt = count_r + 8'h01;
        end
        down_leg_nxt = 1'b0;
      end
      ebt_pkg::MODE_UPDOWN: begin
        if (!down_leg_r) begin
          if (count_r == ch_value_r[0]) begin
            if (count_r != ebt_pkg::COUNT_ZERO) begin
              count_nxt = count_r - 8'h01;
              down_leg_nxt = 1'b1;
            end
          end else begin
            count_nxt = count_r + 8'h01;
          end
        end else if (count_r == ebt_pkg::COUNT_ZERO) begin
          count_nxt = 8'h01;
          down_leg_nxt = 1'b0;
          overflow_nxt = 1'b1;
        end else begin
          count_nxt = count_r - 8'h01;
        end
      end
    endcase
  end

  // a clear write wins over a step in the same cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      count_r <= ebt_pkg::COUNT_ZERO;
      down_leg_r <= 1'b0;
      step_r <= 1'b0;
      overflow_evt_r <= 1'b0;
    end else begin
      step_r <= 1'b0;
      overflow_evt_r <= 1'b0;
      if (wr_ctrl && wr_byte[ebt_pkg::CLEAR_BIT]) begin
        count_r <= ebt_pkg::COUNT_ZERO;
        down_leg_r <= 1'b0;
      end else if (load_down) begin
        count_r <= ch_value_r[0];
        down_leg_r <= 1'b1;
      end else if (prescale_edge) begin
        count_r <= count_nxt;
        down_leg_r <= down_leg_nxt;
        step_r <= 1'b1;
        overflow_evt_r <= overflow_nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // compare channels
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      ebt_chan_if chan_bus ();
      assign chan_bus.count = count_r;
      assign chan_bus.step = step_r;
      assign chan_bus.updown = (mode_r == ebt_pkg::MODE_UPDOWN);
      assign chan_bus.down_leg = down_leg_r;
      assign chan_bus.enable = ch_ctrl_r[gi][ebt_pkg::CH_EN_BIT];
      assign chan_bus.action = ch_ctrl_r[gi][ebt_pkg::ACT_MSB:ebt_pkg::ACT_LSB];
      assign chan_bus.compare_value = ch_value_r[gi];
      // channel 0 pivots on the range ends, channel 1 on channel 0's value
      assign chan_bus.alt_clear_value = (gi == 0) ? ebt_pkg::COUNT_TOP : ch_value_r[0];
      assign chan_bus.alt_set_value = (gi == 0) ? ebt_pkg::COUNT_ZERO : ch_value_r[0];
      assign ch_event[gi] = chan_bus.event_hit;
      assign ch_level[gi] = chan_bus.level;
      ebt_compare_channel u_channel (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .ch(chan_bus.channel)
      );
    end
  endgenerate

  assign compare_out = ch_level;

  // ---------------------------------------------------------------
  // pending flags: a set in the clearing cycle survives
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      overflow_pending_r <= 1'b0;
      channel0_pending_r <= 1'b0;
      channel1_pending_r <= 1'b0;
    end else begin
      if (overflow_evt_r) begin
        overflow_pending_r <= 1'b1;
      end else if (wr_flags && !wr_byte[ebt_pkg::OVF_PEND_BIT]) begin
        overflow_pending_r <= 1'b0;
      end
      if (ch_event[0]) begin
        channel0_pending_r <= 1'b1;
      end else if (wr_flags && !wr_byte[ebt_pkg::CH0_PEND_BIT]) begin
        channel0_pending_r <= 1'b0;
      end
      if (ch_event[1]) begin
        channel1_pending_r <= 1'b1;
      end else if (wr_flags && !wr_byte[ebt_pkg::CH1_PEND_BIT]) begin
        channel1_pending_r <= 1'b0;
      end
    end
  end

  // masks gate the request lines, the flags themselves always record
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_r <= 3'h0;
    end else begin
      irq_r[0] <= overflow_pending_r && overflow_irq_mask_r;
      irq_r[1] <= channel0_pending_r && ch_ctrl_r[0][ebt_pkg::CH_MASK_BIT];
      irq_r[2] <= channel1_pending_r && ch_ctrl_r[1][ebt_pkg::CH_MASK_BIT];
    end
  end

  assign irq_request_out = irq_r;

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  assign s_axi_arready_out = !rvalid_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;
  assign rd_idx = s_axi_araddr_in[9:2];
  assign rd_mapped = (s_axi_araddr_in[ADDR_W-1:10] == '0) && (s_axi_araddr_in[1:0] == 2'h0)
    && (rd_idx >= ebt_pkg::IDX_COUNT_VALUE) && (rd_idx <= ebt_pkg::IDX_PENDING_FLAGS);

  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      ebt_pkg::IDX_COUNT_VALUE: rd_byte = count_r;
      ebt_pkg::IDX_TIMER_CONTROL: rd_byte = {div_r, run_r, overflow_irq_mask_r, 1'b0, mode_r};
      ebt_pkg::IDX_CH0_CONTROL: rd_byte = ch_ctrl_r[0];
      ebt_pkg::IDX_CH0_VALUE: rd_byte = ch_value_r[0];
      ebt_pkg::IDX_CH1_CONTROL: rd_byte = ch_ctrl_r[1];
      ebt_pkg::IDX_CH1_VALUE: rd_byte = ch_value_r[1];
      ebt_pkg::IDX_PENDING_FLAGS: rd_byte = {2'h0, channel1_pending_r, channel0_pending_r,
        overflow_pending_r, 3'h0};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= ebt_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h0, rd_mapped ? rd_byte : 8'h00};
      rresp_r <= rd_mapped ? ebt_pkg::RESP_OKAY : ebt_pkg::RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready_in) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule

// >>> testbench/ebt_timer_sva.sv
`timescale 1ns/100ps
module ebt_timer_sva #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic tick_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic [1:0] compare_out,
  input wire logic [2:0] irq_request_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic [ADDR_W-1:0] rd_addr_r;
  // remembers which register the pending read answer belongs to
  always_ff @(posedge clk_in) begin
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      rd_addr_r <= s_axi_araddr_in;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  sequence s_wr_take;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  // the register and bvalid both update one edge after the take, so the answer is seen two edges after it
  property p_wr_answer; s_wr_take |-> ##2 s_axi_bvalid_out; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write unanswered");
  property p_b_hold; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out; endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_b_block; s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out; endproperty
  a_b_block: assert property (p_b_block) else $error("write taken early");
  property p_rd_answer; s_rd_take |=> s_axi_rvalid_out && s_axi_rdata_out[31:8] == 24'h0; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("bad read answer");
  property p_ar_block; s_axi_arready_out == !s_axi_rvalid_out; endproperty
  a_ar_block: assert property (p_ar_block) else $error("arready wrong");
  property p_clear_reads0;
    s_axi_rvalid_out && rd_addr_r == ADDR_W'({ebt_pkg::IDX_TIMER_CONTROL, 2'h0})
      |-> !s_axi_rdata_out[2];
  endproperty
  a_clear_reads0: assert property (p_clear_reads0) else $error("clear bit read 1");
  // compare outputs move only as a consequence of a counter step
  property p_cmp_cause;
    $changed(compare_out) |-> $past(tick_in) || $past(tick_in, 2) || $past(tick_in, 3);
  endproperty
  a_cmp_cause: assert property (p_cmp_cause) else $error("compare out moved alone");
  property p_reset_quiet; $fell(reset_in) |-> compare_out == 2'h0 && irq_request_out == 3'h0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not idle");
endmodule
bind ebt_timer ebt_timer_sva #(.ADDR_W(ADDR_W)) i_ebt_timer_sva (
  .clk_in, .reset_in, .tick_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rvalid_out,
  .compare_out, .irq_request_out
);

// >>> testbench/test_eight_bit_timer_two_compare.sv
`timescale 1ns/100ps
module test_eight_bit_timer_two_compare;
  localparam logic [7:0] A_CNT = ebt_pkg::IDX_COUNT_VALUE;
  localparam logic [7:0] A_CTL = ebt_pkg::IDX_TIMER_CONTROL;
  localparam logic [7:0] A_C0 = ebt_pkg::IDX_CH0_CONTROL;
  localparam logic [7:0] A_V1 = ebt_pkg::IDX_CH1_VALUE;
  localparam logic [7:0] A_PF = ebt_pkg::IDX_PENDING_FLAGS;
  logic clk_in = 1'h0, reset_in = 1'h1, tick = 1'h0, aw_v = 1'h0, w_v = 1'h0;
  logic b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0, aw_r, w_r, b_v, ar_r, r_v;
  logic [11:0] aw_a = 12'h0, ar_a = 12'h0;
  logic [31:0] w_d = 32'h0, r_d;
  logic [1:0] b_rs, r_rs, cmp;
  logic [2:0] irq;
  int errors = 0;
  int checks_done = 0;
  always #10 clk_in = ~clk_in;
  ebt_timer i_ebt_timer (
    .clk_in(clk_in), .reset_in(reset_in), .tick_in(tick),
    .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v), .s_axi_awready_out(aw_r),
    .s_axi_wdata_in(w_d), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(w_v),
    .s_axi_wready_out(w_r), .s_axi_bresp_out(b_rs), .s_axi_bvalid_out(b_v),
    .s_axi_bready_in(b_r), .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v),
    .s_axi_arready_out(ar_r), .s_axi_rdata_out(r_d), .s_axi_rresp_out(r_rs),
    .s_axi_rvalid_out(r_v), .s_axi_rready_in(r_r), .compare_out(cmp), .irq_request_out(irq)
  );
  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    aw_a <= {2'h0, idx, 2'h0};
    w_d <= {24'h0, d};
    aw_v <= 1'h1;
    w_v <= 1'h1;
    fork
      begin
        do @(posedge clk_in); while (!aw_r);
        aw_v <= 1'h0;
      end
      begin
        do @(posedge clk_in); while (!w_r);
        w_v <= 1'h0;
      end
    join
    // late bready lets the response be seen waiting
    repeat (2) @(posedge clk_in);
    b_r <= 1'h1;
    do @(posedge clk_in); while (!b_v);
    b_r <= 1'h0;
    chk("bresp", {30'h0, b_rs}, 32'h0);
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] e);
    ar_a <= {2'h0, idx, 2'h0};
    ar_v <= 1'h1;
    r_r <= 1'h1;
    do @(posedge clk_in); while (!ar_r);
    ar_v <= 1'h0;
    // rready stays up between reads, so back-to-back calls never drive it twice at once
    do @(posedge clk_in); while (!r_v);
    chk($sformatf("reg %h", idx), r_d, {24'h0, e});
    chk("rresp", {30'h0, r_rs}, {30'h0, ((idx > A_PF) ? 2'h2 : 2'h0)});
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      tick <= 1'h1;
      @(posedge clk_in);
    end
    tick <= 1'h0;
    // one idle edge lets flags raised by the last step settle
    @(posedge clk_in);
  endtask
  // compare output trails the counter step by up to two edges
  task automatic co(input logic [1:0] e);
    repeat (2) @(posedge clk_in);
    chk("compare", {30'h0, cmp}, {30'h0, e});
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_values();
    logic [7:0] idx [8] = '{A_CNT, A_CTL, A_C0, 8'hed, 8'hee, A_V1, A_PF, 8'hf4};
    logic [7:0] e [8] = '{8'h00, 8'h08, 8'h40, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rc(idx[i], e[i]);
    end
    wr(A_CNT, 8'h55);
    rc(A_CNT, 8'h00);
  endtask
  task automatic t_prescale();
    for (int d = 0; d < 8; d++) begin
      wr(A_CTL, {d[2:0], 5'h18});
      ticks(1 << d);
      rc(A_CNT, 8'(d + 1));
    end
    wr(A_CTL, 8'h08);
    ticks(4);
    rc(A_CNT, 8'h08);
    wr(A_CTL, 8'h0c);
    rc(A_CNT, 8'h00);
    rc(A_CTL, 8'h08);
  endtask
  task automatic t_wrap();
    wr(A_CTL, 8'h18);
    ticks(255);
    rc(A_CNT, 8'hff);
    ticks(1);
    rc(A_PF, 8'h08);
    chk("irq", {29'h0, irq}, 32'h1);
    wr(A_CTL, 8'h10);
    chk("irq", {29'h0, irq}, 32'h0);
    wr(A_PF, 8'h38);
    rc(A_PF, 8'h08);
    wr(A_PF, 8'h00);
    rc(A_PF, 8'h00);
  endtask
  task automatic t_compare();
    wr(A_CTL, 8'h0c);
    wr(8'hed, 8'h05);
    wr(A_C0, 8'h44);
    wr(A_V1, 8'h03);
    wr(8'hee, 8'h54);
    wr(A_CTL, 8'h1a);
    ticks(3);
    co(2'h2);
    ticks(3);
    rc(A_CNT, 8'h00);
    co(2'h3);
    rc(A_PF, 8'h38);
    chk("irq", {29'h0, irq}, 32'h7);
    wr(A_C0, 8'h4c);
    ticks(5);
    co(2'h0);
  endtask
  task automatic t_down();
    wr(A_CTL, 8'h0c);
    wr(A_C0, 8'h74);
    wr(8'hee, 8'h5c);
    wr(A_CTL, 8'h19);
    ticks(2);
    rc(A_CNT, 8'h03);
    co(2'h2);
    ticks(6);
    rc(A_CNT, 8'h00);
    co(2'h1);
  endtask
  task automatic t_updown();
    wr(A_CTL, 8'h0c);
    wr(8'hee, 8'h6c);
    wr(A_CTL, 8'h1b);
    ticks(5);
    co(2'h0);
    ticks(2);
    rc(A_CNT, 8'h03);
    co(2'h2);
  endtask
  // whole run is about 750 cycles, so this only trips on a hang
  initial begin
    repeat (5000) @(posedge clk_in);
    errors++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    reset_in <= 1'h0;
    t_reset_values();
    t_prescale();
    t_wrap();
    t_compare();
    t_down();
    t_updown();
    conclude();
  end
endmodule
